// ---- hw/halt_pwr_pkg.sv ----
// Package for the halt power mode controller: register map, field positions, states and timing counts.
// Assumes a single 250 MHz clock domain and an AHB-Lite slave with 32-bit data.
package halt_pwr_pkg;

    // Register byte offsets.
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] status_offset = 8'h04;
    localparam logic [7:0] cc_offset = 8'h08;

    // Control register fields.
    localparam int ctrl_oie_bit = 0;
    localparam int ctrl_long_delay_bit = 1;
    localparam int ctrl_wdg_halt_bit = 2;
    localparam logic [2:0] ctrl_reset_value = 3'h0;

    // Opcode and interrupt level values.
    localparam logic [7:0] halt_opcode = 8'h8e;
    localparam logic [1:0] halt_ilevel = 2'h2;

    // Stabilisation delay in CPU cycles.
    localparam logic [12:0] short_delay_cycles = 13'h0100;
    localparam logic [12:0] long_delay_cycles = 13'h1000;

    // AHB-Lite transfer type.
    localparam logic [1:0] htrans_nonseq = 2'h2;

    typedef enum logic [2:0] {
        st_run,
        st_active_halt,
        st_full_halt,
        st_stabilize,
        st_watch
    } pwr_state_e;

    typedef struct packed {
        pwr_state_e state;
        logic [12:0] count;
        logic service_irq;
        logic osc_interrupt_enable;
        logic long_delay;
        logic wdg_halt;
        logic [1:0] ilevel;
        logic [1:0] saved_ilevel;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic timebase_clk_en;
        logic wdg_reset;
        logic irq_ack;
        logic bus_pend;
        logic bus_write;
        logic [7:0] bus_addr;
        logic [31:0] rdata;
    } pwr_regs_s;

endpackage : halt_pwr_pkg

// ---- hw/halt_power_mode_control.sv ----
// Halt power mode controller: timebase-retaining halt, full halt, wake-up and oscillator settle wait.
// Assumes the CPU core presents decoded opcodes, interrupt requests and stack events synchronously.

// Function
// - Halt with oscillator interrupt enable set enters the timebase-retaining halt.
// - Halt with oscillator interrupt enable clear enters full halt.
// - Timebase halt exits only on timebase interrupt, wake interrupt or reset.
// - Interrupt wake from timebase halt skips the settle wait and services at once.
// - Reset wake from timebase halt applies the settle wait, then reset vector.
// - Entering either halt forces interrupt level bits to binary 10.
// - Timebase halt runs only oscillator and timebase counter; other clocks stop.
// - With oscillator interrupt enabled, timebase halt with watchdog active causes no reset.
// - Clearing the enable during the post-wake interval stops CPU and peripherals for the rest of it.
// - Full halt exits only on a wake interrupt or reset.
// - Full halt exit restarts oscillator and waits 256 or 4096 cycles.
// - Full halt stops the main oscillator and all internal clocks.
// - Watchdog halt option makes halt from run with watchdog enabled and oscillator interrupt enable clear reset instead.
// - Wake service saves condition code levels and sets routine priority; pop restores.
// - Opcode 0x8e is decoded as the halt instruction.
module halt_power_mode_control (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic haddr_sel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic opcode_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic timebase_irq_i,
    input wire logic wake_irq_i,
    input wire logic wdg_enabled_i,
    input wire logic [1:0] irq_priority_i,
    input wire logic cc_pop_i,
    input wire logic reset_wake_i,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_en_o,
    output logic timebase_clk_en_o,
    output logic wdg_reset_o,
    output logic irq_ack_o,
    output logic [1:0] ilevel_o
);

    halt_pwr_pkg::pwr_regs_s q;
    halt_pwr_pkg::pwr_regs_s d;

    // Decoded events and shared helper terms of the sequencer.
    logic halt_exec;
    logic [12:0] delay_target;
    logic bus_take;
    logic ctrl_write;
    logic active_wake;
    logic [12:0] count_next;
    logic settle_done;

    // Halt is decoded from the opcode stream; only a valid fetch counts.
    // A data byte equal to the halt opcode on an idle bus therefore never stops the part.
    assign halt_exec = opcode_valid_i && (opcode_i == halt_pwr_pkg::halt_opcode);

    // The option bit picks the settle length for every wait that follows.
    // It is read live, so changing it while a wait runs moves the end of that wait.
    assign delay_target = q.long_delay ? halt_pwr_pkg::long_delay_cycles : halt_pwr_pkg::short_delay_cycles;

    // A transfer is taken only in a valid address phase; idle cycles are ignored.
    assign bus_take = haddr_sel_i && hready_i && (htrans_i == halt_pwr_pkg::htrans_nonseq);

    // The data phase of a write to the control word; writes to any other offset are dropped.
    assign ctrl_write = q.bus_pend && q.bus_write && (q.bus_addr == halt_pwr_pkg::ctrl_offset);

    // Besides reset, only the timebase interrupt and the wake-capable interrupts end the timebase-retaining halt.
    assign active_wake = timebase_irq_i || wake_irq_i;

    // One counter serves both the settle wait and the post-wake interval, as the two never overlap.
    // The count is thirteen bits, so the long wait fits with room to spare and the adder cannot wrap.
    assign count_next = q.count + 13'h0001;
    assign settle_done = (count_next >= delay_target);

    // Next-state logic for the power sequencer and the register slave.
    // Every field holds its value unless a branch below moves it; the two pulses drop each cycle, and bus_pend and rdata are rebuilt each cycle.
    always_comb begin
        d = q;
        d.irq_ack = 1'b0;
        d.wdg_reset = 1'b0;

        // Bus address phase is captured; the data phase completes with zero wait states.
        // The slave never stalls, so a debug host can reach it in every power state.
        d.bus_pend = bus_take;
        if (bus_take) begin
            d.bus_write = hwrite_i;
            d.bus_addr = haddr_i[7:0];
        end

        // The control word lands at the end of its data phase.
        if (ctrl_write) begin
            d.osc_interrupt_enable = hwdata_i[halt_pwr_pkg::ctrl_oie_bit];
            d.long_delay = hwdata_i[halt_pwr_pkg::ctrl_long_delay_bit];
            d.wdg_halt = hwdata_i[halt_pwr_pkg::ctrl_wdg_halt_bit];
        end

        // Stack events move the interrupt level bits.
        if (cc_pop_i) begin
            d.ilevel = q.saved_ilevel;
        end

        case (q.state)
            // Run: the halt instruction picks its target from the oscillator interrupt enable.
            // With the enable set the watchdog cannot fire, so its halt option only matters
            // on the way into full halt.
            halt_pwr_pkg::st_run: begin
                if (halt_exec) begin
                    if (q.osc_interrupt_enable) begin
                        d.state = halt_pwr_pkg::st_active_halt;
                        d.ilevel = halt_pwr_pkg::halt_ilevel;
                        d.cpu_clk_en = 1'b0;
                        d.periph_clk_en = 1'b0;
                    end else if (wdg_enabled_i && q.wdg_halt) begin
                        d.wdg_reset = 1'b1;
                    end else begin
                        d.state = halt_pwr_pkg::st_full_halt;
                        d.ilevel = halt_pwr_pkg::halt_ilevel;
                        d.cpu_clk_en = 1'b0;
                        d.periph_clk_en = 1'b0;
                        d.osc_en = 1'b0;
                        d.timebase_clk_en = 1'b0;
                    end
                end
            end
            // Timebase-retaining halt: oscillator and timebase keep running, CPU and peripherals stop.
            // Reset wins over an interrupt in the same cycle, as the reset vector replaces any service.
            halt_pwr_pkg::st_active_halt: begin
                if (reset_wake_i) begin
                    // A reset still pays the full settle wait before the CPU restarts.
                    d.state = halt_pwr_pkg::st_stabilize;
                    d.service_irq = 1'b0;
                    d.count = 13'h0000;
                end else if (active_wake) begin
                    // The oscillator never stopped, so the CPU is released in the next cycle.
                    d.state = halt_pwr_pkg::st_watch;
                    d.cpu_clk_en = 1'b1;
                    d.periph_clk_en = 1'b1;
                    d.irq_ack = 1'b1;
                    d.saved_ilevel = q.ilevel;
                    d.ilevel = irq_priority_i;
                    d.count = 13'h0000;
                end
            end
            // Full halt: the oscillator is off, so only a wake-capable interrupt or a reset gets out.
            // The timebase interrupt cannot arrive here because its counter is stopped as well.
            halt_pwr_pkg::st_full_halt: begin
                if (reset_wake_i || wake_irq_i) begin
                    d.state = halt_pwr_pkg::st_stabilize;
                    d.service_irq = !reset_wake_i;
                    d.osc_en = 1'b1;
                    d.count = 13'h0000;
                end
            end
            // Settle wait: the oscillator runs (the timebase too if it never stopped); CPU and peripherals wait until the count is done.
            // An interrupt that woke the part is serviced on release, with its level saved first.
            halt_pwr_pkg::st_stabilize: begin
                // The count only advances with the oscillator running.
                d.count = count_next;
                d.osc_en = 1'b1;
                if (settle_done) begin
                    d.state = halt_pwr_pkg::st_run;
                    d.cpu_clk_en = 1'b1;
                    d.periph_clk_en = 1'b1;
                    d.timebase_clk_en = 1'b1;
                    if (q.service_irq) begin
                        d.irq_ack = 1'b1;
                        d.saved_ilevel = q.ilevel;
                        d.ilevel = irq_priority_i;
                    end
                end
            end
            // Post-wake interval: the CPU runs while the counter measures the settle length.
            halt_pwr_pkg::st_watch: begin
                // An early clear of the enable falls into the settle wait, CPU and peripherals stopped, for the remainder of the interval.
                // The oscillator keeps running through it, so the remainder is counted, not restarted.
                d.count = count_next;
                if (!q.osc_interrupt_enable) begin
                    d.state = halt_pwr_pkg::st_stabilize;
                    d.service_irq = 1'b0;
                    d.cpu_clk_en = 1'b0;
                    d.periph_clk_en = 1'b0;
                    if (halt_exec) begin
                        d.ilevel = halt_pwr_pkg::halt_ilevel;
                    end
                end else if (halt_exec) begin
                    // The CPU is running, so a new halt with the enable set goes back to the timebase halt.
                    d.state = halt_pwr_pkg::st_active_halt;
                    d.ilevel = halt_pwr_pkg::halt_ilevel;
                    d.cpu_clk_en = 1'b0;
                    d.periph_clk_en = 1'b0;
                end else if (settle_done) begin
                    d.state = halt_pwr_pkg::st_run;
                end
            end
            // An illegal state code can only come from an upset; falling back to run keeps the part alive.
            default: begin
                d.state = halt_pwr_pkg::st_run;
            end
        endcase

        // Read data for the next data phase; unmapped words read zero.
        // The control word returns the value after any write landing in the same cycle, so a read
        // straight after a write sees the new setting; status and levels show the current state.
        d.rdata = 32'h0000_0000;
        if (bus_take && !hwrite_i) begin
            if (haddr_i[7:0] == halt_pwr_pkg::ctrl_offset) begin
                d.rdata = {29'h0, d.wdg_halt, d.long_delay, d.osc_interrupt_enable};
            end else if (haddr_i[7:0] == halt_pwr_pkg::status_offset) begin
                d.rdata = {24'h0, q.cpu_clk_en, q.osc_en, q.periph_clk_en, q.timebase_clk_en, 1'b0, q.state};
            end else if (haddr_i[7:0] == halt_pwr_pkg::cc_offset) begin
                d.rdata = {28'h0, q.saved_ilevel, q.ilevel};
            end
        end
    end

    // State register; reset puts the device in run with all clocks on.
    // Interrupt levels come up at three, masking everything until software lowers them.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.state <= halt_pwr_pkg::st_run;
            q.cpu_clk_en <= 1'b1;
            q.periph_clk_en <= 1'b1;
            q.osc_en <= 1'b1;
            q.timebase_clk_en <= 1'b1;
            q.ilevel <= 2'h3;
            q.saved_ilevel <= 2'h3;
        end else begin
            q <= d;
        end
    end

    // Bus outputs; the slave is always ready and always answers OKAY.
    assign hrdata_o = q.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Clock enables, pulses and levels leave straight from the state register, free of glitches.
    assign cpu_clk_en_o = q.cpu_clk_en;
    assign periph_clk_en_o = q.periph_clk_en;
    assign osc_en_o = q.osc_en;
    assign timebase_clk_en_o = q.timebase_clk_en;
    assign wdg_reset_o = q.wdg_reset;
    assign irq_ack_o = q.irq_ack;
    assign ilevel_o = q.ilevel;

endmodule : halt_power_mode_control

// ---- sim/halt_pwr_props.sv ----
// Checker for the halt power mode controller: clock gating, wake-up and level forcing.
// Assumes one clock domain and the top module's port names.
module halt_pwr_props (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic opcode_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic timebase_irq_i,
    input wire logic wake_irq_i,
    input wire logic wdg_enabled_i,
    input wire logic [1:0] irq_priority_i,
    input wire logic reset_wake_i,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic osc_en_o,
    input wire logic timebase_clk_en_o,
    input wire logic wdg_reset_o,
    input wire logic irq_ack_o,
    input wire logic [1:0] ilevel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // A pending interrupt would wake at once, so entry is only checked with none pending.
    a_halt_entry: assert property (opcode_valid_i && opcode_i == 8'h8e && cpu_clk_en_o && !wdg_enabled_i
        && !wake_irq_i && !timebase_irq_i |=> ilevel_o == 2'h2 && !cpu_clk_en_o && !periph_clk_en_o)
        else $error("halt opcode did not stop the cpu with level 2");
    a_active_clocks: assert property (timebase_clk_en_o && !cpu_clk_en_o |-> osc_en_o)
        else $error("timebase runs without the oscillator");
    a_full_osc_off: assert property (!osc_en_o |-> !cpu_clk_en_o && !periph_clk_en_o && !timebase_clk_en_o)
        else $error("clock running while oscillator stopped");
    a_active_wake: assert property (!cpu_clk_en_o && timebase_clk_en_o && (timebase_irq_i || wake_irq_i)
        && !reset_wake_i |=> cpu_clk_en_o && irq_ack_o)
        else $error("interrupt wake from timebase halt not immediate");
    a_full_wake_osc: assert property (!osc_en_o && wake_irq_i |=> osc_en_o)
        else $error("oscillator not restarted on wake");
    a_settle_hold: assert property ($rose(osc_en_o) |-> !cpu_clk_en_o [*8])
        else $error("cpu released without settle wait");
    a_no_wdg_active: assert property (timebase_clk_en_o && !cpu_clk_en_o |-> !wdg_reset_o)
        else $error("watchdog reset in timebase halt");
    a_ack_level: assert property (irq_ack_o |-> ilevel_o == $past(irq_priority_i))
        else $error("service level differs from priority");
    a_full_stays: assert property (!osc_en_o && !wake_irq_i && !reset_wake_i |=> !osc_en_o)
        else $error("full halt left without cause");
    c_active: cover property (!cpu_clk_en_o && timebase_clk_en_o ##1 irq_ack_o);
    c_settle: cover property ($rose(osc_en_o));
    c_wdg: cover property (wdg_reset_o);
endmodule : halt_pwr_props

bind halt_power_mode_control halt_pwr_props u_props (.*);

// ---- sim/halt_cpu_model.sv ----
// Model of the CPU core and an interrupt source beside the controller.
// Assumes halt and interrupt requests from the bench, one cycle each.
module halt_cpu_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic halt_req_i,
    input wire logic irq_req_i,
    input wire logic irq_ack_i,
    output logic opcode_valid_o,
    output logic [7:0] opcode_o,
    output logic wake_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins and pending flags are set up before halting the request latch clears on service.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            opcode_valid_o <= 1'b0;
            opcode_o <= 8'h71;
            wake_irq_o <= 1'b0;
        end else begin
            opcode_valid_o <= halt_req_i;
            opcode_o <= halt_req_i ? 8'h8e : ~opcode_o; // Idle bus toggles between 0x71 and the halt opcode 0x8e.
            wake_irq_o <= irq_req_i | (wake_irq_o & ~irq_ack_i);
        end
    end
endmodule : halt_cpu_model

// ---- sim/halt_power_mode_control_tb.sv ----
// Testbench for the halt power mode controller over AHB-Lite and the CPU model.
// Assumes a zero-wait slave and the register map of the package.
module halt_power_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_b_i = 0, haddr_sel_i = 0, hwrite_i = 0, timebase_irq_i = 0, wdg_enabled_i = 0;
    logic cc_pop_i = 0, reset_wake_i = 0, halt_req = 0, irq_req = 0, opcode_valid_i, wake_irq_i, hready_i;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
    logic [1:0] htrans_i = 0, irq_priority_i = 2'h1, ilevel_o;
    logic [2:0] hsize_i = 3'h2;
    logic [7:0] opcode_i;
    logic hreadyout_o, hresp_o, cpu_clk_en_o, periph_clk_en_o, osc_en_o, timebase_clk_en_o, wdg_reset_o, irq_ack_o;
    int mismatches = 0, n_checks = 0, cyc = 0, n;
    assign hready_i = hreadyout_o;
    halt_power_mode_control u_halt_power_mode_control (.*);
    halt_cpu_model u_halt_cpu_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .halt_req_i(halt_req), .irq_req_i(irq_req),
        .irq_ack_i(irq_ack_o), .opcode_valid_o(opcode_valid_i), .opcode_o(opcode_i), .wake_irq_o(wake_irq_i));
    always #2 clk_i = ~clk_i;
    // A hang ends the run as a failure rather than stalling.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One single transfer; the master waits on hready in both phases.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        {haddr_sel_i, htrans_i, hwrite_i, haddr_i} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(posedge clk_i); while (hready_i !== 1'b1);
        {haddr_sel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, wd};
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
        chk({hreadyout_o, hresp_o}, 2'h2);
    endtask : bus
    task automatic pulse_halt(input logic tb_wake, input logic [5:0] exp_halt);
        @(posedge clk_i) halt_req <= 1'b1;
        @(posedge clk_i) halt_req <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({cpu_clk_en_o, periph_clk_en_o, osc_en_o, timebase_clk_en_o, ilevel_o}, exp_halt);
        if (tb_wake) irq_req <= 1'b1;
        else reset_wake_i <= 1'b1;
        @(posedge clk_i) {irq_req, reset_wake_i} <= 2'b00;
    endtask : pulse_halt
    task automatic settle_count();
        n = 1;
        while (cpu_clk_en_o !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
    endtask : settle_count
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        chk({cpu_clk_en_o, periph_clk_en_o, osc_en_o, timebase_clk_en_o, ilevel_o}, 6'h3f);
        bus(1'b0, 8'h00, 0); chk(rd, 32'h0);
        bus(1'b1, 8'h0c, 32'hffff_ffff); bus(1'b0, 8'h0c, 0); chk(rd, 32'h0);
        // Timebase halt: only oscillator and timebase run, interrupt wakes with no wait.
        bus(1'b1, 8'h00, 32'h1);
        @(posedge clk_i) halt_req <= 1'b1;
        @(posedge clk_i) halt_req <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({cpu_clk_en_o, periph_clk_en_o, osc_en_o, timebase_clk_en_o, ilevel_o}, 6'h0e);
        bus(1'b0, 8'h04, 0); chk(rd, 32'h51);
        timebase_irq_i <= 1'b1;
        @(posedge clk_i) timebase_irq_i <= 1'b0;
        @(posedge clk_i) chk({cpu_clk_en_o, irq_ack_o, ilevel_o}, 4'hd);
        bus(1'b0, 8'h08, 0); chk(rd[1:0], 2'h1);
        @(posedge clk_i) cc_pop_i <= 1'b1;
        @(posedge clk_i) cc_pop_i <= 1'b0;
        @(posedge clk_i) chk(ilevel_o, 2'h2);
        // Clearing the enable inside the post-wake interval stops the CPU for the rest of it, no service.
        bus(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(cpu_clk_en_o, 1'b0);
        settle_count(); chk({n > 200 && n < 256, irq_ack_o}, 2'h2);
        // Full halt with the short wait, woken by an interrupt.
        pulse_halt(1'b1, 6'h02);
        settle_count(); chk(n >= 256 && n <= 260, 1);
        // Full halt with the long wait, woken by reset.
        bus(1'b1, 8'h00, 32'h2);
        pulse_halt(1'b0, 6'h02);
        settle_count(); chk(n >= 4096 && n <= 4100, 1);
        // Timebase halt woken by reset takes the short settle wait and services nothing.
        bus(1'b1, 8'h00, 32'h1);
        pulse_halt(1'b0, 6'h0e);
        settle_count(); chk({n >= 256 && n <= 260, irq_ack_o}, 2'h2);
        // Watchdog option turns the halt into a watchdog reset.
        bus(1'b1, 8'h00, 32'h4);
        bus(1'b0, 8'h00, 0); chk(rd, 32'h4);
        wdg_enabled_i <= 1'b1;
        @(posedge clk_i) halt_req <= 1'b1;
        @(posedge clk_i) halt_req <= 1'b0;
        n = 0;
        repeat (4) @(posedge clk_i) n = n | wdg_reset_o;
        chk(n, 1);
        finish_test();
    end
endmodule : halt_power_mode_control_tb
